// ---- rtl/lrp_desc_parser.sv ----
// linkage and return link descriptor parser with apb register access
// assumes one descriptor byte per in_valid cycle, bytes synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "lrp_regs.svh"

module lrp_desc_parser import lrp_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// apb slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// descriptor byte stream
	input  wire logic              in_valid,
	input  wire logic [7:0]        in_byte,
	input  wire lrp_table_t        in_table,
	// results
	output logic                   desc_done,
	output logic                   pop_match,
	output logic                   len_err
);

	if (ADDR_W < 8) begin : g_bad_addr
		$error("lrp_desc_parser: ADDR_W must be at least 8");
	end

	// bcd position to tenths of a degree, with a flag for an illegal digit
	function automatic logic [13:0] bcd_tenths(input logic [15:0] b);
		logic [13:0] acc;
		acc = 14'(b[15:12]) * 14'd1000;
		acc = acc + 14'(b[11:8]) * 14'd100;
		acc = acc + 14'(b[7:4]) * 14'd10;
		acc = acc + 14'(b[3:0]);
		return acc;
	endfunction : bcd_tenths

	function automatic logic bcd_bad(input logic [15:0] b);
		return (b[15:12] > 4'h9) | (b[11:8] > 4'h9) | (b[7:4] > 4'h9) | (b[3:0] > 4'h9);
	endfunction : bcd_bad

	// software registers
	logic        ctrl_en_ff;
	logic        clr_ff;
	logic [7:0]  tag_link_ff;
	logic [7:0]  tag_ret_ff;
	logic [15:0] popid_ff;
	// parser state
	lrp_state_t  state_ff;
	lrp_state_t  nxt_state;
	lrp_kind_t   kind_ff;
	lrp_table_t  table_ff;
	logic [7:0]  rem_ff;
	logic [3:0]  idx_ff;
	logic [7:0]  rng_left_ff;
	logic [15:0] base_ff;
	logic [7:0]  mask_hi_ff;
	logic        match_acc_ff;
	logic [7:0]  priv_cnt_ff;
	// decoded fields
	logic [15:0] fwd_mux_ff;
	logic [15:0] second_id_ff;
	logic        second_is_orig_ff;
	logic [15:0] svc_ident_ff;
	logic [7:0]  ltype_ff;
	logic [15:0] interactive_net_ident_ff;
	logic [7:0]  range_count_minus_one_ff;
	logic [7:0]  sat_ident_ff;
	logic [15:0] spot_ident_ff;
	logic [7:0]  hub_ident_ff;
	logic [15:0] orbit_bcd_ff;
	logic        east_ff;
	logic [7:0]  sf_seq_ff;
	logic [23:0] tx_off_ff;
	// result flops
	logic        done_ff;
	logic        match_ff;
	logic        lerr_ff;
	logic        link_seen_ff;
	logic        ret_seen_ff;
	// apb flops
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;

	logic        take;
	logic        last;
	logic        body;
	logic        mand;
	logic        go_priv;
	logic        hit;
	logic        done_evt;
	logic        err_evt;
	logic        range_end;
	lrp_kind_t   tag_kind;

	// one byte per valid cycle while enabled; a byte in the soft clear cycle is dropped
	assign take = in_valid & ctrl_en_ff & ~clr_ff;
	assign last = (rem_ff == 8'h01);
	assign body = (state_ff != ST_TAG) && (state_ff != ST_LEN);
	assign mand = body && (state_ff != ST_PRIV) && (state_ff != ST_SKIP);
	assign range_end = (state_ff == ST_LK_RANGE) && (idx_ff[1:0] == 2'h3);
	assign tag_kind = (in_byte == tag_link_ff) ? KIND_LINK :
	                  (in_byte == tag_ret_ff) ? KIND_RET : KIND_OTHER;

	// range matcher on the byte that completes the mask
	lrp_range_match #(
		.ID_W(16)
	) u_match (
		.own_id              (popid_ff),
		.range_base_value    (base_ff),
		.range_wildcard_bits ({mask_hi_ff, in_byte}),
		.hit                 (hit)
	);

	// next state of the byte walker
	always_comb begin
		nxt_state = state_ff;
		go_priv = 1'b0;
		if (take) begin
			unique case (state_ff)
				ST_TAG: nxt_state = ST_LEN;
				ST_LEN: begin
					if (in_byte == 8'h00) nxt_state = ST_TAG;
					else if (kind_ff == KIND_LINK) nxt_state = ST_LK_HEAD;
					else if (kind_ff == KIND_RET) nxt_state = ST_RL_BODY;
					else nxt_state = ST_SKIP;
				end
				ST_LK_HEAD: begin
					if (idx_ff == `LRP_LK_HEAD_LAST) begin
						go_priv = (table_ff != TBL_MAP);
						nxt_state = go_priv ? ST_PRIV : ST_LK_INET;
					end
				end
				ST_LK_INET: if (idx_ff == `LRP_LK_INET_LAST) nxt_state = ST_LK_CNT;
				ST_LK_CNT: nxt_state = ST_LK_RANGE;
				ST_LK_RANGE: begin
					go_priv = range_end && (rng_left_ff == 8'h00);
					if (go_priv) nxt_state = ST_PRIV;
				end
				ST_RL_BODY: begin
					go_priv = (idx_ff == `LRP_RL_BODY_LAST);
					if (go_priv) nxt_state = ST_PRIV;
				end
				ST_PRIV: nxt_state = ST_PRIV;
				ST_SKIP: nxt_state = ST_SKIP;
			endcase
			if (body && last) nxt_state = ST_TAG;
		end
	end

	// descriptor ends on its last byte or on a zero length
	assign done_evt = take && (((state_ff == ST_LEN) && (in_byte == 8'h00)) || (body && last));
	assign err_evt = take && (((state_ff == ST_LEN) && (in_byte == 8'h00) && (kind_ff != KIND_OTHER))
	                 || (mand && last && !go_priv));

	// walker state, cleared by reset or soft clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_TAG;
		end else if (clr_ff) begin
			state_ff <= ST_TAG;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// byte counters: remaining length, index inside a field group, ranges left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_ff <= 8'h00;
			idx_ff <= 4'h0;
			rng_left_ff <= 8'h00;
		end else if (clr_ff) begin
			rem_ff <= 8'h00;
			idx_ff <= 4'h0;
			rng_left_ff <= 8'h00;
		end else if (take) begin
			if (state_ff == ST_LEN) rem_ff <= in_byte;
			else if (body) rem_ff <= rem_ff - 8'h01;
			idx_ff <= (nxt_state != state_ff) ? 4'h0 : idx_ff + 4'h1;
			if (state_ff == ST_LK_CNT) rng_left_ff <= in_byte;
			else if (range_end) rng_left_ff <= rng_left_ff - 8'h01;
		end
	end

	// kind and carrying table caught at the tag byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_ff <= KIND_OTHER;
			table_ff <= TBL_OTHER;
		end else if (take && (state_ff == ST_TAG)) begin
			kind_ff <= tag_kind;
			table_ff <= in_table;
		end
	end

	// linkage fields, shifted in msb first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_mux_ff <= 16'h0000;
			second_id_ff <= 16'h0000;
			second_is_orig_ff <= 1'b0;
			svc_ident_ff <= 16'h0000;
			ltype_ff <= 8'h00;
			interactive_net_ident_ff <= 16'h0000;
			range_count_minus_one_ff <= 8'h00;
		end else if (take && (state_ff == ST_LK_HEAD)) begin
			unique case (idx_ff)
				4'h0, 4'h1: fwd_mux_ff <= {fwd_mux_ff[7:0], in_byte};
				4'h2, 4'h3: begin
					second_id_ff <= {second_id_ff[7:0], in_byte};
					second_is_orig_ff <= (table_ff == TBL_NETWORK);
				end
				4'h4, 4'h5: svc_ident_ff <= {svc_ident_ff[7:0], in_byte};
				4'h6: ltype_ff <= in_byte;
				default: ;
			endcase
		end else if (take && (state_ff == ST_LK_INET)) begin
			interactive_net_ident_ff <= {interactive_net_ident_ff[7:0], in_byte};
		end else if (take && (state_ff == ST_LK_CNT)) begin
			range_count_minus_one_ff <= in_byte;
		end
	end

	// range base and upper mask byte, and the running match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_ff <= 16'h0000;
			mask_hi_ff <= 8'h00;
			match_acc_ff <= 1'b0;
		end else if (clr_ff || (take && (state_ff == ST_TAG))) begin
			match_acc_ff <= 1'b0;
		end else if (take && (state_ff == ST_LK_RANGE)) begin
			unique case (idx_ff[1:0])
				2'h0, 2'h1: base_ff <= {base_ff[7:0], in_byte};
				2'h2: mask_hi_ff <= in_byte;
				2'h3: if (hit) match_acc_ff <= 1'b1;
			endcase
		end
	end

	// return link fields by byte index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sat_ident_ff <= 8'h00;
			spot_ident_ff <= 16'h0000;
			hub_ident_ff <= 8'h00;
			orbit_bcd_ff <= 16'h0000;
			east_ff <= 1'b0;
			sf_seq_ff <= 8'h00;
			tx_off_ff <= 24'h000000;
		end else if (take && (state_ff == ST_RL_BODY)) begin
			unique case (idx_ff)
				4'h0: sat_ident_ff <= in_byte;
				4'h1, 4'h2: spot_ident_ff <= {spot_ident_ff[7:0], in_byte};
				4'h3: hub_ident_ff <= in_byte;
				4'h4: ; // reserved byte skipped
				4'h5, 4'h6: orbit_bcd_ff <= {orbit_bcd_ff[7:0], in_byte};
				4'h7: east_ff <= in_byte[0];
				4'h8: sf_seq_ff <= in_byte;
				4'h9, 4'ha, 4'hb: begin
					if (table_ff == TBL_UNICAST) tx_off_ff <= {tx_off_ff[15:0], in_byte};
					else tx_off_ff <= 24'h000000;
				end
				default: ;
			endcase
		end
	end

	// private bytes are only counted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priv_cnt_ff <= 8'h00;
		end else if (clr_ff || (take && (state_ff == ST_TAG))) begin
			priv_cnt_ff <= 8'h00;
		end else if (take && (state_ff == ST_PRIV)) begin
			priv_cnt_ff <= priv_cnt_ff + 8'h01;
		end
	end

	// done pulse with match and length error held until the next descriptor ends or a soft clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			match_ff <= 1'b0;
			lerr_ff <= 1'b0;
			link_seen_ff <= 1'b0;
			ret_seen_ff <= 1'b0;
		end else if (clr_ff) begin
			done_ff <= 1'b0;
			match_ff <= 1'b0;
			lerr_ff <= 1'b0;
		end else begin
			done_ff <= done_evt;
			if (done_evt) begin
				match_ff <= (kind_ff == KIND_LINK) &&
				            (match_acc_ff || (range_end && hit));
				lerr_ff <= err_evt;
				if (kind_ff == KIND_LINK) link_seen_ff <= 1'b1;
				if (kind_ff == KIND_RET) ret_seen_ff <= 1'b1;
			end
		end
	end

	// control, tag and population registers written in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_ff <= `LRP_CTRL_EN_RST;
			clr_ff <= 1'b0;
			tag_link_ff <= `LRP_TAG_LINK_RST;
			tag_ret_ff <= `LRP_TAG_RET_RST;
			popid_ff <= `LRP_POPID_RST;
		end else begin
			clr_ff <= 1'b0;
			if (psel && penable && pready_ff && pwrite && !pslverr_ff) begin
				unique case (paddr[7:0])
					`LRP_OFF_CTRL: begin
						ctrl_en_ff <= pwdata[`LRP_CTRL_EN_BIT];
						clr_ff <= pwdata[`LRP_CTRL_CLR_BIT];
					end
					`LRP_OFF_TAGS: begin
						tag_link_ff <= pwdata[7:0];
						tag_ret_ff <= pwdata[15:8];
					end
					`LRP_OFF_POPID: popid_ff <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// read mux and decode of legal addresses
	logic [31:0] rd_data;
	logic        rd_err;
	logic        addr_ok;
	assign addr_ok = (paddr[ADDR_W-1:0] >> 8) == '0;
	always_comb begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		unique case (paddr[7:0])
			`LRP_OFF_CTRL: rd_data = {30'h0, 1'b0, ctrl_en_ff};
			`LRP_OFF_TAGS: rd_data = {16'h0000, tag_ret_ff, tag_link_ff};
			`LRP_OFF_POPID: rd_data = {16'h0000, popid_ff};
			`LRP_OFF_STATUS: begin
				rd_data[`LRP_ST_BUSY_BIT] = (state_ff != ST_TAG);
				rd_data[`LRP_ST_MATCH_BIT] = match_ff;
				rd_data[`LRP_ST_LERR_BIT] = lerr_ff;
				rd_data[`LRP_ST_LINK_BIT] = link_seen_ff;
				rd_data[`LRP_ST_RET_BIT] = ret_seen_ff;
				rd_data[`LRP_ST_BCDERR_BIT] = bcd_bad(orbit_bcd_ff);
			end
			`LRP_OFF_MUX: rd_data = {second_id_ff, fwd_mux_ff};
			`LRP_OFF_SVC: rd_data = {interactive_net_ident_ff, svc_ident_ff};
			`LRP_OFF_LINK: begin
				rd_data[15:0] = {range_count_minus_one_ff, ltype_ff};
				rd_data[`LRP_LK_TS_BIT] = second_is_orig_ff ? 1'b0 :
				                          (ltype_ff == `LRP_LTYPE_TS_FLS);
				rd_data[`LRP_LK_GSE_BIT] = second_is_orig_ff ? 1'b0 :
				                           (ltype_ff == `LRP_LTYPE_GSE_FLS);
				rd_data[`LRP_LK_MAP_BIT] = second_is_orig_ff &&
				                           (ltype_ff == `LRP_LTYPE_MAP);
				rd_data[`LRP_LK_ORIG_BIT] = second_is_orig_ff;
			end
			`LRP_OFF_SAT: rd_data = {hub_ident_ff, spot_ident_ff, sat_ident_ff};
			`LRP_OFF_ORBIT: rd_data = {sf_seq_ff, 7'h00, east_ff, orbit_bcd_ff};
			`LRP_OFF_TXOFF: rd_data = {{8{tx_off_ff[23]}}, tx_off_ff};
			`LRP_OFF_PRIV: rd_data = {24'h000000, priv_cnt_ff};
			`LRP_OFF_ORBDEC: rd_data = {18'h00000, bcd_tenths(orbit_bcd_ff)};
			default: rd_err = 1'b1;
		endcase
		if (!addr_ok) begin
			rd_data = 32'h00000000;
			rd_err = 1'b1;
		end
	end

	// zero wait answer: ready and data are set up in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel && !penable;
			pslverr_ff <= psel && !penable && rd_err;
			prdata_ff <= (psel && !penable && !pwrite) ? rd_data : 32'h00000000;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign desc_done = done_ff;
	assign pop_match = match_ff;
	assign len_err = lerr_ff;

endmodule : lrp_desc_parser

`default_nettype wire

// ---- rtl/lrp_range_match.sv ----
// population range matcher: tests one identifier against a base and wildcard pair
// assumes all inputs stable in the cycle the hit is read
`timescale 1ns/10ps
`default_nettype none

module lrp_range_match import lrp_pkg::*; #(
	parameter int ID_W = 16
) (
	// operands
	input  wire logic [ID_W-1:0] own_id,
	input  wire logic [ID_W-1:0] range_base_value,
	input  wire logic [ID_W-1:0] range_wildcard_bits,
	// result
	output logic                 hit
);

	if (ID_W < 1) begin : g_bad_width
		$error("lrp_range_match: ID_W must be positive");
	end

	// wildcard bits pass always, other bits must equal the base
	assign hit = &(range_wildcard_bits | ~(own_id ^ range_base_value));

endmodule : lrp_range_match

`default_nettype wire

// ---- shared/lrp_pkg.sv ----
// types shared by the descriptor parser files
// assumes nothing beyond a systemverilog compiler
package lrp_pkg;

	// table that carried the descriptor
	typedef enum logic [1:0] {
		TBL_NETWORK,
		TBL_MAP,
		TBL_UNICAST,
		TBL_OTHER
	} lrp_table_t;

	// descriptor kind chosen at the tag byte
	typedef enum logic [1:0] {
		KIND_LINK,
		KIND_RET,
		KIND_OTHER
	} lrp_kind_t;

	// parser states
	typedef enum logic [3:0] {
		ST_TAG,
		ST_LEN,
		ST_LK_HEAD,
		ST_LK_INET,
		ST_LK_CNT,
		ST_LK_RANGE,
		ST_RL_BODY,
		ST_PRIV,
		ST_SKIP
	} lrp_state_t;

endpackage : lrp_pkg

// ---- shared/lrp_regs.svh ----
// register offsets, field positions, reset values and field codes for the descriptor parser
// assumes a 32-bit apb slave with byte addresses and one aligned word per register
`ifndef LRP_REGS_SVH
`define LRP_REGS_SVH

// register byte offsets
`define LRP_OFF_CTRL      8'h00
`define LRP_OFF_TAGS      8'h04
`define LRP_OFF_POPID     8'h08
`define LRP_OFF_STATUS    8'h0c
`define LRP_OFF_MUX       8'h10
`define LRP_OFF_SVC       8'h14
`define LRP_OFF_LINK      8'h18
`define LRP_OFF_SAT       8'h1c
`define LRP_OFF_ORBIT     8'h20
`define LRP_OFF_TXOFF     8'h24
`define LRP_OFF_PRIV      8'h28
`define LRP_OFF_ORBDEC    8'h2c

// control fields
`define LRP_CTRL_EN_BIT   0
`define LRP_CTRL_CLR_BIT  1
`define LRP_CTRL_EN_RST   1'b1

// descriptor tag and own id defaults, software may reprogram them
`define LRP_TAG_LINK_RST  8'h00
`define LRP_TAG_RET_RST   8'h00
`define LRP_POPID_RST     16'h0000

// status fields
`define LRP_ST_BUSY_BIT   0
`define LRP_ST_MATCH_BIT  1
`define LRP_ST_LERR_BIT   2
`define LRP_ST_LINK_BIT   3
`define LRP_ST_RET_BIT    4
`define LRP_ST_BCDERR_BIT 5

// linkage info fields
`define LRP_LK_TS_BIT     16
`define LRP_LK_GSE_BIT    17
`define LRP_LK_MAP_BIT    18
`define LRP_LK_ORIG_BIT   19

// linkage type codes
`define LRP_LTYPE_TS_FLS  8'h81
`define LRP_LTYPE_GSE_FLS 8'h82
`define LRP_LTYPE_MAP     8'h07

// fixed field groups after the length byte, last index of each group
`define LRP_LK_HEAD_LAST  4'h6
`define LRP_LK_INET_LAST  4'h1
`define LRP_RL_BODY_LAST  4'hb

`endif

// ---- tb/linkage_return_link_desc_parser_tb.sv ----
// testbench for the descriptor parser: register access and descriptor scenarios
// assumes the byte source model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module linkage_return_link_desc_parser_tb import lrp_pkg::*;;
	localparam logic [7:0]  LT = 8'h4a; // linkage tag, arbitrary
	localparam logic [7:0]  RT = 8'h4b; // return link tag, arbitrary
	localparam logic [31:0] F = 32'hffffffff;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        in_valid, desc_done, pop_match, len_err, slow, m, le;
	logic [7:0]  paddr, in_byte;
	logic [31:0] pwdata, prdata;
	lrp_table_t  in_table;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	// 40 ns clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	lrp_desc_parser uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .in_valid(in_valid), .in_byte(in_byte), .in_table(in_table),
		.desc_done(desc_done), .pop_match(pop_match), .len_err(len_err));
	lrp_byte_src src (.pclk(pclk), .presetn(presetn), .slow(slow), .in_valid(in_valid),
		.in_byte(in_byte), .in_table(in_table));
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'(pready), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] k,
		input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r & k, x);
	endtask : rdc
	task automatic snd(input lrp_table_t t, input logic [7:0] b[$]);
		@(negedge pclk);
		foreach (b[i]) src.push({t, b[i]});
	endtask : snd
	task automatic wait_done(output logic mt, output logic er);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (desc_done !== 1'b1 && n < 200);
		chk("desc_done", 32'(desc_done), 32'h1);
		mt = pop_match;
		er = len_err;
	endtask : wait_done
	// reset values, refused access, tag and own id setup
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rdc("ctrl", 8'h00, F, 32'h1);
		rdc("tags", 8'h04, F, 32'h0);
		rdc("popid", 8'h08, F, 32'h0);
		rdc("status", 8'h0c, F, 32'h0);
		apb(1'b0, 8'h30, 32'h0, r, e);
		chk("unmapped_err", 32'(e), 32'h1);
		chk("unmapped_data", r, 32'h0);
		wr(8'h04, {16'h0, RT, LT});
		wr(8'h08, 32'h1234);
		rdc("tags_back", 8'h04, F, {16'h0, RT, LT});
	endtask : t_regs
	// map linkage, two ranges, second hits through its mask, source stalls
	task automatic t_map_two();
		@(posedge pclk);
		slow <= 1'b1;
		snd(TBL_MAP, '{LT, 8'h13, 8'hab, 8'h01, 8'hcd, 8'h02, 8'hef, 8'h03, 8'h82, 8'h5a, 8'h06,
			8'h01, 8'h12, 8'h35, 8'h00, 8'h00, 8'h12, 8'h04, 8'h00, 8'h30, 8'h77});
		wait_done(m, le);
		slow <= 1'b0;
		chk("match", 32'(m), 32'h1);
		chk("len_err", 32'(le), 32'h0);
		rdc("mux", 8'h10, F, 32'hcd02ab01);
		rdc("svc", 8'h14, F, 32'h5a06ef03);
		rdc("link", 8'h18, 32'h000fffff, 32'h00020182);
		rdc("priv", 8'h28, F, 32'h1);
	endtask : t_map_two
	// one range that misses by one bit; private bytes would match if read as a range
	task automatic t_map_one();
		snd(TBL_MAP, '{LT, 8'h12, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h81, 8'h00, 8'h01,
			8'h00, 8'h12, 8'h35, 8'h00, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00});
		wait_done(m, le);
		chk("miss", 32'(m), 32'h0);
		rdc("link_ts", 8'h18, 32'h000fffff, 32'h00010081);
		rdc("priv4", 8'h28, F, 32'h4);
	endtask : t_map_one
	// network linkage then unicast return link, no gap
	task automatic t_net_ret();
		snd(TBL_NETWORK, '{LT, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
		snd(TBL_UNICAST, '{RT, 8'h0d, 8'h11, 8'h22, 8'h33, 8'h44, 8'hff, 8'h01, 8'h92, 8'hff,
			8'h55, 8'hff, 8'hfe, 8'h0c, 8'h99});
		wait_done(m, le);
		chk("net_match", 32'(m), 32'h0);
		wait_done(m, le);
		rdc("net_mux", 8'h10, F, 32'h03040102);
		rdc("net_svc", 8'h14, 32'hffff, 32'h0506);
		rdc("net_link", 8'h18, 32'h000c00ff, 32'h000c0007);
		rdc("sat", 8'h1c, F, 32'h44223311);
		rdc("orbit", 8'h20, 32'hff01ffff, 32'h55010192);
		rdc("txoff", 8'h24, F, 32'hfffffe0c);
		rdc("orbdec", 8'h2c, F, 32'hc0);
	endtask : t_net_ret
	// other-table return link, short linkage, empty linkage, no gaps
	task automatic t_short();
		snd(TBL_OTHER, '{RT, 8'h0c, 8'h21, 8'h00, 8'h07, 8'h31, 8'h00, 8'h12, 8'h34, 8'hfe,
			8'h66, 8'h00, 8'h00, 8'h00});
		snd(TBL_NETWORK, '{LT, 8'h03, 8'haa, 8'hbb, 8'hcc, LT, 8'h00});
		wait_done(m, le);
		chk("ret_err", 32'(le), 32'h0);
		wait_done(m, le);
		chk("short_err", 32'(le), 32'h1);
		wait_done(m, le);
		chk("empty_err", 32'(le), 32'h1);
		rdc("sat2", 8'h1c, F, 32'h31000721);
		rdc("orbit2", 8'h20, 32'hff01ffff, 32'h66001234);
		rdc("txoff0", 8'h24, F, 32'h0);
		rdc("orbdec2", 8'h2c, F, 32'h4d2);
		rdc("status2", 8'h0c, F, 32'h1c);
	endtask : t_short
	// soft clear drops results, parser restarts at a tag
	task automatic t_clear();
		wr(8'h00, 32'h3);
		repeat (3) @(posedge pclk);
		#1;
		chk("clr_err", 32'(len_err), 32'h0);
		rdc("ctrl_clr", 8'h00, F, 32'h1);
		snd(TBL_NETWORK, '{8'h11, 8'h02, LT, 8'h00, LT, 8'h00});
		wait_done(m, le);
		chk("skip_err", 32'(le), 32'h0);
		wait_done(m, le);
		chk("after_clr", 32'(le), 32'h1);
	endtask : t_clear
	// reset, then the scenarios
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_map_two();
		t_map_one();
		t_net_ret();
		t_short();
		t_clear();
		end_sim();
	end
endmodule : linkage_return_link_desc_parser_tb
bind lrp_desc_parser lrp_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
	.in_byte(in_byte), .in_table(in_table), .desc_done(desc_done), .pop_match(pop_match),
	.len_err(len_err));
`default_nettype wire

// ---- tb/lrp_byte_src.sv ----
// upstream extractor model: sends queued bytes with their table, may stall
// assumes the bench fills the queue through push away from the rising edge
`timescale 1ns/10ps
`default_nettype none
module lrp_byte_src import lrp_pkg::*; (
	// clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// one idle cycle after each byte when set
	input  wire logic  slow,
	// byte stream
	output logic       in_valid,
	output logic [7:0] in_byte,
	output lrp_table_t in_table
);
	logic [9:0] q[$];
	logic       gap_ff;
	logic [9:0] ent;
	// queue entry: table above byte
	task automatic push(input logic [9:0] e);
		q.push_back(e);
	endtask : push
	// one byte per valid cycle, lines toggle while idle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_valid <= 1'b0;
			in_byte <= 8'h00;
			in_table <= TBL_NETWORK;
			gap_ff <= 1'b0;
		end else if (q.size() > 0 && !gap_ff) begin
			ent = q.pop_front();
			in_valid <= 1'b1;
			in_byte <= ent[7:0];
			in_table <= lrp_table_t'(ent[9:8]);
			gap_ff <= slow;
		end else begin
			in_valid <= 1'b0;
			in_byte <= ~in_byte; // no stale byte while idle
			in_table <= lrp_table_t'(~in_table);
			gap_ff <= 1'b0;
		end
	end
endmodule : lrp_byte_src
`default_nettype wire

// ---- tb/lrp_desc_parser_asserts.sv ----
// checker for the descriptor parser: apb answer, done timing, result hold
// assumes en stays set and both tags are programmed before any descriptor
`timescale 1ns/10ps
`default_nettype none
module lrp_chk import lrp_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// apb
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// byte stream
	input  wire logic              in_valid,
	input  wire logic [7:0]        in_byte,
	input  wire lrp_table_t        in_table,
	// results
	input  wire logic              desc_done,
	input  wire logic              pop_match,
	input  wire logic              len_err
);
	logic [1:0]  ph_ff;
	logic [7:0]  rem_ff;
	logic [15:0] tag_ff;
	logic        known_ff;
	logic        clr_ff;
	logic        clr2_ff;
	logic        wr;
	logic        take;
	logic        last;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// write strobe and byte framing seen at the ports
	assign wr = psel && penable && pready && pwrite;
	assign take = in_valid && !clr_ff;
	assign last = take && ((ph_ff == 2'h1 && in_byte == 8'h00) || (ph_ff == 2'h2 && rem_ff == 8'h01));
	// soft clear seen one and two cycles back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_ff <= 1'b0;
			clr2_ff <= 1'b0;
		end else begin
			clr_ff <= wr && paddr == ADDR_W'(0) && pwdata[1];
			clr2_ff <= clr_ff;
		end
	end
	// programmed tags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_ff <= 16'h0000;
		end else if (wr && paddr == ADDR_W'(4)) begin
			tag_ff <= pwdata[15:0];
		end
	end
	// tag, length, body tracker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_ff <= 2'h0;
			rem_ff <= 8'h00;
			known_ff <= 1'b0;
		end else if (clr_ff) begin
			ph_ff <= 2'h0;
		end else if (take) begin
			if (ph_ff == 2'h0) begin
				ph_ff <= 2'h1;
				known_ff <= in_byte == tag_ff[7:0] || in_byte == tag_ff[15:8];
			end else if (ph_ff == 2'h1) begin
				ph_ff <= (in_byte == 8'h00) ? 2'h0 : 2'h2;
				rem_ff <= in_byte;
			end else begin
				ph_ff <= (rem_ff == 8'h01) ? 2'h0 : 2'h2;
				rem_ff <= rem_ff - 8'h01;
			end
		end
	end
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer one cycle after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_unmapped_a: assert property (pready && paddr > ADDR_W'(44) |-> pslverr)
		else $error("unmapped access not refused");
	done_on_last_a: assert property (last |=> desc_done)
		else $error("no done after last byte");
	done_cause_a: assert property ($rose(desc_done) |-> $past(last))
		else $error("done without last byte");
	done_pulse_a: assert property (desc_done |=> !desc_done)
		else $error("done longer than one cycle");
	match_hold_a: assert property (!desc_done && !clr_ff && !clr2_ff |-> $stable(pop_match))
		else $error("match changed between dones");
	lerr_hold_a: assert property (!desc_done && !clr_ff && !clr2_ff |-> $stable(len_err))
		else $error("length error changed between dones");
	zero_len_a: assert property (last && ph_ff == 2'h1 && known_ff |=> len_err)
		else $error("empty known descriptor not flagged");
	cover property (desc_done && pop_match);
	cover property (desc_done && len_err);
	cover property (pready && pslverr);
endmodule : lrp_chk
`default_nettype wire
